// [rtl/urb_fifo.sv]
// Two-entry receive buffer; the head is a register.
// Assumes push is only offered while count is below two.
`timescale 1ns/1ps
`default_nettype none
module urb_fifo
   import urb_pkg::*;
(
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_sys_rst,
   // Control
   input  wire logic       i_flush,
   input  wire logic       i_push,
   input  wire urb_entry_t i_entry,
   input  wire logic       i_pop,
   // State
   output urb_entry_t      o_head,
   output logic [1:0]      o_count
);

   urb_entry_t tail_r;
   logic       do_pop;

   assign do_pop = i_pop && (o_count != 2'd0);

   // -----------------------------------------------------------------
   // Storage shifts toward the head on a pop
   // -----------------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst || i_flush)
      begin
         o_head  <= '0;
         tail_r  <= '0;
         o_count <= 2'd0;
      end
      else
      begin
         unique case ({i_push, do_pop})
            2'b10:
            begin
               if (o_count == 2'd0)
                  o_head <= i_entry;
               else
                  tail_r <= i_entry;
               o_count <= o_count + 2'd1;
            end
            2'b01:
            begin
               o_head  <= tail_r;
               tail_r  <= '0;
               o_count <= o_count - 2'd1;
            end
            2'b11:
            begin
               if (o_count == 2'd1)
                  o_head <= i_entry;
               else
               begin
                  o_head <= tail_r;
                  tail_r <= i_entry;
               end
            end
            default:
            begin
            end
         endcase
      end
   end

endmodule : urb_fifo
`default_nettype wire

// [rtl/urb_pkg.sv]
// Constants and types for the receive buffer and status block.
// Assumes a single system clock; no other package is needed.
package urb_pkg;

   // -----------------------------------------------------------------
   // Register byte addresses
   // -----------------------------------------------------------------
   localparam logic [7:0] URB_OFS_STAT_A = 8'h00;
   localparam logic [7:0] URB_OFS_CTRL_B = 8'h04;
   localparam logic [7:0] URB_OFS_CTRL_C = 8'h08;
   localparam logic [7:0] URB_OFS_DATA   = 8'h0C;
   localparam logic [7:0] URB_OFS_DIV    = 8'h10;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int URB_A_RXC   = 7;
   localparam int URB_A_FE    = 4;
   localparam int URB_A_DOR   = 3;
   localparam int URB_A_UPE   = 2;
   localparam int URB_B_RXCIE = 7;
   localparam int URB_B_RXEN  = 4;
   localparam int URB_B_SZ2   = 2;
   localparam int URB_B_RX9   = 1;
   localparam int URB_B_TX9   = 0;
   localparam int URB_C_PEN   = 5;
   localparam int URB_C_PODD  = 4;
   localparam int URB_C_STOP  = 3;
   localparam int URB_C_SZLO  = 1;

   // -----------------------------------------------------------------
   // Reset values and encodings
   // -----------------------------------------------------------------
   localparam logic [2:0]  URB_RST_SIZE = 3'h3;
   localparam logic [2:0]  URB_SIZE_9   = 3'h7;
   localparam logic [15:0] URB_RST_DIV  = 16'h0010;
   localparam logic [1:0]  URB_RESP_OK  = 2'h0;
   localparam logic [1:0]  URB_RESP_ERR = 2'h2;
   localparam int          URB_DEPTH    = 2;

   // One receive buffer entry
   typedef struct packed {
      logic [8:0] data;
      logic       fe;
      logic       dor;
      logic       upe;
   } urb_entry_t;

   // Receiver states, one-hot
   typedef enum logic [4:0] {
      URB_IDLE  = 5'b00001,
      URB_START = 5'b00010,
      URB_DATA  = 5'b00100,
      URB_PAR   = 5'b01000,
      URB_STOP  = 5'b10000
   } urb_state_t;

endpackage : urb_pkg

// [rtl/urb_rx_top.sv]
// Receive side of a serial port: frame capture, buffer and status.
// Assumes an AXI4-Lite master on i_clk and a serial line on the pin.
//
// Notes on behaviour
// - A data read pops the buffer, exposing the next entry.
// - Receive-complete reads one while any unread character is held.
// - Clearing receiver enable flushes the buffer, receive-complete drops.
// - Interrupt requested while flag, its enable and global enable are set.
// - Error flags stored per entry and shown for the head entry.
// - Writes to the status register never alter the error flags.
// - Error flags never raise an interrupt.
// - Frame error is one when the first stop bit sampled low.
// - Only the first stop bit is checked, whatever the stop setting.
// - Overrun when buffer full, character waiting and new start bit seen.
// - Overrun cleared when a frame moves into the buffer.
// - Parity checked only when enabled; odd select picks the sense.
// - Parity computed over data, compared, outcome stored with data.
// - Parity error set only for a failed, checked character, until read.
// - Parity error reads zero while checking is disabled.
// - Disabling the receiver abandons any character in progress at once.
// - A disabled receiver releases the serial input pin.
// - Frame moves to the buffer after the first stop bit.
// - Unused upper data bits of short characters read as zero.
// - An enabled receiver takes the pin as its serial input.
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module urb_rx_top
   import urb_pkg::*;
(
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   // AXI4-Lite write
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   output logic [1:0]       o_bresp,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   // AXI4-Lite read
   input  wire logic [7:0]  i_araddr,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   // Serial line and system
   input  wire logic        i_serial_input_pin,
   input  wire logic        i_global_irq_en,
   output logic             o_pin_override,
   output logic             o_rx_irq
);
   import urb_pkg::*;

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   logic        rx_complete_irq_enable_r;
   logic        receiver_enable_bit_r;
   logic        tx_ninth_bit_r;
   logic        parity_enable_bit_r;
   logic        parity_odd_select_r;
   logic        stop_bits_select_r;
   logic [2:0]  char_size_field_r;
   logic [15:0] div_r;
   logic [7:0]  wr_addr_r;
   logic [31:0] wr_data_r;
   logic [3:0]  wr_strb_r;
   logic        do_write;
   logic        rd_take;
   logic        pop;
   logic        pin_s1_r;
   logic        pin_s2_r;
   logic        prev_r;
   urb_state_t  state_r;
   logic [15:0] timer_r;
   logic [3:0]  idx_r;
   logic [8:0]  shreg_r;
   logic        par_r;
   logic        wait_r;
   logic        ovr_pend_r;
   urb_entry_t  wait_entry_r;
   urb_entry_t  new_entry;
   urb_entry_t  push_entry;
   logic        push;
   logic        done;
   logic        full;
   logic        start_seen;
   urb_entry_t  head;
   logic [1:0]  count;
   logic [3:0]  nbits;
   logic [8:0]  size_mask;
   logic        rxc;

   assign rxc        = (count != 2'd0);
   assign full       = (count == 2'(URB_DEPTH));
   assign start_seen = receiver_enable_bit_r && prev_r && !pin_s2_r;
   assign nbits      = (char_size_field_r == URB_SIZE_9) ? 4'd9 :
                       (char_size_field_r[2] ? 4'd8 : 4'(char_size_field_r) + 4'd5);
   assign size_mask  = 9'(9'h1FF >> (4'd9 - nbits));

   // -----------------------------------------------------------------
   // AXI4-Lite write channel
   // -----------------------------------------------------------------
   assign do_write = !o_awready && !o_wready && !o_bvalid;

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         o_awready <= 1'b1;
         o_wready  <= 1'b1;
         o_bvalid  <= 1'b0;
         o_bresp   <= URB_RESP_OK;
         wr_addr_r <= 8'h00;
         wr_data_r <= 32'h0000_0000;
         wr_strb_r <= 4'h0;
      end
      else
      begin
         if (i_awvalid && o_awready)
         begin
            o_awready <= 1'b0;
            wr_addr_r <= i_awaddr;
         end
         if (i_wvalid && o_wready)
         begin
            o_wready  <= 1'b0;
            wr_data_r <= i_wdata;
            wr_strb_r <= i_wstrb;
         end
         if (do_write)
         begin
            o_bvalid <= 1'b1;
            o_bresp  <= (wr_addr_r > URB_OFS_DIV || wr_addr_r[1:0] != 2'b00) ?
                        URB_RESP_ERR : URB_RESP_OK;
         end
         if (o_bvalid && i_bready)
         begin
            o_bvalid  <= 1'b0;
            o_awready <= 1'b1;
            o_wready  <= 1'b1;
         end
      end
   end

   // Control fields; status and data writes change nothing here
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         rx_complete_irq_enable_r <= 1'b0;
         receiver_enable_bit_r    <= 1'b0;
         tx_ninth_bit_r           <= 1'b0;
         parity_enable_bit_r      <= 1'b0;
         parity_odd_select_r      <= 1'b0;
         stop_bits_select_r       <= 1'b0;
         char_size_field_r        <= URB_RST_SIZE;
         div_r                    <= URB_RST_DIV;
      end
      else if (do_write && wr_strb_r[0])
      begin
         if (wr_addr_r == URB_OFS_CTRL_B)
         begin
            rx_complete_irq_enable_r <= wr_data_r[URB_B_RXCIE];
            receiver_enable_bit_r    <= wr_data_r[URB_B_RXEN];
            char_size_field_r[2]     <= wr_data_r[URB_B_SZ2];
            tx_ninth_bit_r           <= wr_data_r[URB_B_TX9];
         end
         if (wr_addr_r == URB_OFS_CTRL_C)
         begin
            parity_enable_bit_r    <= wr_data_r[URB_C_PEN];
            parity_odd_select_r    <= wr_data_r[URB_C_PODD];
            stop_bits_select_r     <= wr_data_r[URB_C_STOP];
            char_size_field_r[1:0] <= wr_data_r[URB_C_SZLO +: 2];
         end
         if (wr_addr_r == URB_OFS_DIV)
         begin
            div_r[7:0] <= wr_data_r[7:0];
            if (wr_strb_r[1])
               div_r[15:8] <= wr_data_r[15:8];
         end
      end
      else if (do_write && wr_strb_r[1] && wr_addr_r == URB_OFS_DIV)
         div_r[15:8] <= wr_data_r[15:8];
   end

   // -----------------------------------------------------------------
   // AXI4-Lite read channel
   // -----------------------------------------------------------------
   assign rd_take = i_arvalid && o_arready;
   assign pop     = rd_take && (i_araddr == URB_OFS_DATA);

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         o_arready <= 1'b1;
         o_rvalid  <= 1'b0;
         o_rdata   <= 32'h0000_0000;
         o_rresp   <= URB_RESP_OK;
      end
      else if (rd_take)
      begin
         o_arready <= 1'b0;
         o_rvalid  <= 1'b1;
         o_rresp   <= URB_RESP_OK;
         o_rdata   <= 32'h0000_0000;
         unique case (i_araddr)
            URB_OFS_STAT_A:
            begin
               o_rdata[URB_A_RXC] <= rxc;
               o_rdata[URB_A_FE]  <= head.fe;
               o_rdata[URB_A_DOR] <= head.dor;
               o_rdata[URB_A_UPE] <= head.upe && parity_enable_bit_r;
            end
            URB_OFS_CTRL_B:
            begin
               o_rdata[URB_B_RXCIE] <= rx_complete_irq_enable_r;
               o_rdata[URB_B_RXEN]  <= receiver_enable_bit_r;
               o_rdata[URB_B_SZ2]   <= char_size_field_r[2];
               o_rdata[URB_B_RX9]   <= head.data[8];
               o_rdata[URB_B_TX9]   <= tx_ninth_bit_r;
            end
            URB_OFS_CTRL_C:
            begin
               o_rdata[URB_C_PEN]          <= parity_enable_bit_r;
               o_rdata[URB_C_PODD]         <= parity_odd_select_r;
               o_rdata[URB_C_STOP]         <= stop_bits_select_r;
               o_rdata[URB_C_SZLO +: 2]    <= char_size_field_r[1:0];
            end
            URB_OFS_DATA: o_rdata[7:0] <= head.data[7:0];
            URB_OFS_DIV:  o_rdata[15:0] <= div_r;
            default:      o_rresp <= URB_RESP_ERR;
         endcase
      end
      else if (o_rvalid && i_rready)
      begin
         o_rvalid  <= 1'b0;
         o_arready <= 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // Pin synchroniser and ownership
   // -----------------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         pin_s1_r       <= 1'b1;
         pin_s2_r       <= 1'b1;
         prev_r         <= 1'b1;
         o_pin_override <= 1'b0;
      end
      else
      begin
         pin_s1_r       <= i_serial_input_pin;
         pin_s2_r       <= pin_s1_r;
         prev_r         <= pin_s2_r;
         o_pin_override <= receiver_enable_bit_r;
      end
   end

   // -----------------------------------------------------------------
   // Frame receiver
   // -----------------------------------------------------------------
   // Single centre sample per bit; noise filtering lives upstream
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst || !receiver_enable_bit_r)
      begin
         state_r <= URB_IDLE;
         timer_r <= 16'h0000;
         idx_r   <= 4'h0;
         shreg_r <= 9'h000;
         par_r   <= 1'b0;
      end
      else
      begin
         timer_r <= (timer_r != 16'h0000) ? timer_r - 16'h0001 : div_r;
         unique case (state_r)
            URB_IDLE:
               if (start_seen && !(wait_r && full))
               begin
                  state_r <= URB_START;
                  timer_r <= div_r >> 1;
               end
            URB_START:
               if (timer_r == 16'h0000)
               begin
                  state_r <= pin_s2_r ? URB_IDLE : URB_DATA;
                  idx_r   <= 4'h0;
                  shreg_r <= 9'h000;
               end
            URB_DATA:
               if (timer_r == 16'h0000)
               begin
                  shreg_r[idx_r] <= pin_s2_r;
                  idx_r          <= idx_r + 4'h1;
                  if (idx_r == nbits - 4'h1)
                     state_r <= parity_enable_bit_r ? URB_PAR : URB_STOP;
               end
            URB_PAR:
               if (timer_r == 16'h0000)
               begin
                  par_r   <= pin_s2_r;
                  state_r <= URB_STOP;
               end
            URB_STOP:
               if (timer_r == 16'h0000)
                  state_r <= URB_IDLE;
            default: state_r <= URB_IDLE;
         endcase
      end
   end

   assign done = (state_r == URB_STOP) && (timer_r == 16'h0000);

   always_comb
   begin
      new_entry      = '0;
      new_entry.data = shreg_r & size_mask;
      new_entry.fe   = !pin_s2_r;
      new_entry.dor  = ovr_pend_r;
      new_entry.upe  = parity_enable_bit_r &&
                       ((^shreg_r) ^ par_r ^ parity_odd_select_r);
      push           = !full && (wait_r || done);
      push_entry     = wait_r ? wait_entry_r : new_entry;
   end

   // Completed character parked while the buffer is full
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst || !receiver_enable_bit_r)
      begin
         wait_r       <= 1'b0;
         ovr_pend_r   <= 1'b0;
         wait_entry_r <= '0;
      end
      else
      begin
         if (done && full)
         begin
            wait_r       <= 1'b1;
            wait_entry_r <= new_entry;
         end
         else if (push)
            wait_r <= 1'b0;
         if (start_seen && wait_r && full)
         begin
            ovr_pend_r       <= 1'b1;
            wait_entry_r.dor <= 1'b1;
         end
         else if (push)
            ovr_pend_r <= 1'b0;
      end
   end

   urb_fifo u_fifo (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_flush   (!receiver_enable_bit_r),
      .i_push    (push),
      .i_entry   (push_entry),
      .i_pop     (pop),
      .o_head    (head),
      .o_count   (count)
   );

   // Error flags play no part in the request
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         o_rx_irq <= 1'b0;
      else
         o_rx_irq <= rxc && rx_complete_irq_enable_r && i_global_irq_en;
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   sequence data_rd_s;
      rd_take && (i_araddr == URB_OFS_DATA);
   endsequence

   sequence stat_rd_s;
      rd_take && (i_araddr == URB_OFS_STAT_A);
   endsequence

   irq_follows_flag_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (rxc && rx_complete_irq_enable_r && i_global_irq_en) |=> o_rx_irq)
      else $error("interrupt not requested while flag set");

   irq_needs_data_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_rx_irq |-> $past(rxc))
      else $error("interrupt raised with empty buffer");

   flush_on_off_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !receiver_enable_bit_r ##1 !receiver_enable_bit_r |-> count == 2'd0)
      else $error("buffer not flushed while disabled");

   pop_one_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      data_rd_s and (count == 2'd1) && !push && receiver_enable_bit_r |=> count == 2'd0)
      else $error("data read did not pop");

   rxc_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      stat_rd_s |=> o_rdata[URB_A_RXC] == $past(rxc))
      else $error("receive-complete read wrong");

   upe_off_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      stat_rd_s and !parity_enable_bit_r |=> !o_rdata[URB_A_UPE])
      else $error("parity error read with checking off");

   stat_write_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      do_write && wr_addr_r == URB_OFS_STAT_A && !pop && !push && receiver_enable_bit_r
      |=> $stable(head))
      else $error("status write changed error flags");

   abort_idle_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !receiver_enable_bit_r |=> state_r == URB_IDLE)
      else $error("receiver kept running when disabled");

   pin_release_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      $fell(receiver_enable_bit_r) |-> ##1 !o_pin_override [*2])
      else $error("pin not released");

   overrun_set_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      start_seen && wait_r && full |=> ovr_pend_r && wait_entry_r.dor)
      else $error("overrun not flagged");

endmodule : urb_rx_top
`default_nettype wire

// [testbench/urb_line_model.sv]
// Remote serial transmitter driving the receive line.
// Assumes the bench clock; one bit lasts BIT clocks.
`timescale 1ns/1ps
`default_nettype none
module urb_line_model #(
   parameter int BIT = 17
) (
   // Clock
   input  wire logic i_clk,
   // Line, idle high
   output logic      o_line
);
   initial o_line = 1'b1;

   task automatic bit_out(input logic v);
      begin
         o_line <= v;
         repeat (BIT) @(posedge i_clk);
      end
   endtask : bit_out

   // Start, nb data bits LSB first, optional parity, one stop
   task automatic send(input logic [8:0] d, input int nb, input logic pon,
                       input logic pb, input logic stop);
      int n;
      begin
         bit_out(1'b0);
         for (n = 0; n < nb; n++)
            bit_out(d[n]);
         if (pon)
            bit_out(pb);
         bit_out(stop);
         // Idle bit: a low stop must still leave a falling edge for the next start
         bit_out(1'b1);
      end
   endtask : send
endmodule : urb_line_model
`default_nettype wire

// [testbench/urb_rx_bench.sv]
// Self-checking bench for the receive buffer and status block.
// Assumes reset divisor, so one serial bit lasts 17 clocks.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
   $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module urb_rx_bench;
   import urb_pkg::*;
   logic        i_clk = 1'b0, i_sys_rst = 1'b1, gie = 1'b0;
   logic [7:0]  awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdat;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [1:0]  rrsp, wrsp;
   wire logic   awready, wready, bvalid, arready, rvalid, irq, ovr, line;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata;
   int          n_mismatch = 0, checks_done = 0;

   urb_rx_top dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_awaddr(awaddr),
      .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF),
      .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
      .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
      .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
      .i_serial_input_pin(line), .i_global_irq_en(gie), .o_pin_override(ovr),
      .o_rx_irq(irq));
   urb_line_model lm (.i_clk(i_clk), .o_line(line));

   always #12.5 i_clk = ~i_clk;

   // -----------------------------------------------------------------
   // Bus tasks
   // -----------------------------------------------------------------
   task automatic end_of_test;
      begin
         if (n_mismatch == 0 && checks_done > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask : end_of_test

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int n;
      begin
         awaddr  <= a;
         wdata   <= {24'h00_0000, d};
         awvalid <= 1'b1;
         wvalid  <= 1'b1;
         bready  <= 1'b1;
         for (n = 0; n < 40 && !(bvalid && bready); n++)
         begin
            @(posedge i_clk);
            if (awready)
               awvalid <= 1'b0;
            if (wready)
               wvalid <= 1'b0;
            wrsp = bresp;
         end
         bready <= 1'b0;
         @(posedge i_clk);
         if (n == 40)
            n_mismatch++;
         if (n == 40)
            end_of_test();
      end
   endtask : wr

   task automatic rd(input logic [7:0] a);
      int n;
      begin
         araddr  <= a;
         arvalid <= 1'b1;
         rready  <= 1'b1;
         for (n = 0; n < 40 && !(rvalid && rready); n++)
         begin
            @(posedge i_clk);
            if (arready)
               arvalid <= 1'b0;
            rdat = rdata;
            rrsp = rresp;
         end
         rready <= 1'b0;
         @(posedge i_clk);
         if (n == 40)
            n_mismatch++;
         if (n == 40)
            end_of_test();
      end
   endtask : rd

   // Status first, then data, as software must
   task automatic pair(input logic [7:0] st, input logic [7:0] dt);
      begin
         rd(URB_OFS_STAT_A);
         `CHK("status", st, rdat[7:0])
         rd(URB_OFS_DATA);
         `CHK("data", {24'h00_0000, dt}, rdat)
      end
   endtask : pair

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_parity;
      begin
         wr(URB_OFS_CTRL_C, 8'h26);
         wr(URB_OFS_CTRL_B, 8'h10);
         `CHK("pin", 1'b1, ovr)
         lm.send(9'h041, 8, 1'b1, 1'b0, 1'b1);
         lm.send(9'h0A5, 8, 1'b1, 1'b1, 1'b1);
         pair(8'h80, 8'h41);
         pair(8'h84, 8'hA5);
         rd(URB_OFS_STAT_A);
         `CHK("empty", 8'h00, rdat[7:0])
         wr(URB_OFS_CTRL_C, 8'h36);
         lm.send(9'h041, 8, 1'b1, 1'b1, 1'b1);
         lm.send(9'h007, 8, 1'b1, 1'b1, 1'b1);
         lm.send(9'h041, 8, 1'b1, 1'b0, 1'b1);
         pair(8'h80, 8'h41);
         pair(8'h84, 8'h07);
         wr(URB_OFS_CTRL_C, 8'h06);
         pair(8'h80, 8'h41);
      end
   endtask : t_parity

   task automatic t_frame;
      int n;
      begin
         wr(URB_OFS_CTRL_C, 8'h0E);
         lm.send(9'h055, 8, 1'b0, 1'b0, 1'b0);
         lm.send(9'h033, 8, 1'b0, 1'b0, 1'b1);
         wr(URB_OFS_STAT_A, 8'h00);
         pair(8'h90, 8'h55);
         pair(8'h80, 8'h33);
         lm.send(9'h066, 8, 1'b0, 1'b0, 1'b1);
         lm.send(9'h077, 8, 1'b0, 1'b0, 1'b1);
         rd(URB_OFS_STAT_A);
         for (n = 0; n < 4 && rdat[URB_A_RXC]; n++)
         begin
            rd(URB_OFS_DATA);
            rd(URB_OFS_STAT_A);
         end
         `CHK("drain reads", 2, n)
         `CHK("drained", 1'b0, rdat[URB_A_RXC])
      end
   endtask : t_frame

   task automatic t_overrun;
      begin
         wr(URB_OFS_CTRL_C, 8'h06);
         lm.send(9'h011, 8, 1'b0, 1'b0, 1'b1);
         lm.send(9'h022, 8, 1'b0, 1'b0, 1'b1);
         lm.send(9'h033, 8, 1'b0, 1'b0, 1'b1);
         lm.send(9'h0FF, 8, 1'b0, 1'b0, 1'b1);
         pair(8'h80, 8'h11);
         pair(8'h80, 8'h22);
         pair(8'h88, 8'h33);
         lm.send(9'h044, 8, 1'b0, 1'b0, 1'b1);
         pair(8'h80, 8'h44);
         rd(8'h14);
         `CHK("unmapped", URB_RESP_ERR, rrsp)
         wr(8'h14, 8'h00);
         `CHK("unmapped write", URB_RESP_ERR, wrsp)
      end
   endtask : t_overrun

   task automatic t_sizes;
      begin
         wr(URB_OFS_CTRL_C, 8'h00);
         lm.send(9'h01F, 5, 1'b0, 1'b0, 1'b1);
         pair(8'h80, 8'h1F);
         wr(URB_OFS_CTRL_B, 8'h14);
         wr(URB_OFS_CTRL_C, 8'h06);
         lm.send(9'h1A5, 9, 1'b0, 1'b0, 1'b1);
         rd(URB_OFS_CTRL_B);
         `CHK("ninth", 8'h16, rdat[7:0])
         pair(8'h80, 8'hA5);
         rd(URB_OFS_CTRL_B);
         `CHK("ninth", 8'h14, rdat[7:0])
      end
   endtask : t_sizes

   task automatic t_irq_flush;
      begin
         wr(URB_OFS_CTRL_B, 8'h90);
         gie <= 1'b1;
         lm.send(9'h05A, 8, 1'b0, 1'b0, 1'b1);
         `CHK("irq", 1'b1, irq)
         gie <= 1'b0;
         repeat (3) @(posedge i_clk);
         `CHK("irq", 1'b0, irq)
         gie <= 1'b1;
         rd(URB_OFS_DATA);
         repeat (3) @(posedge i_clk);
         `CHK("irq", 1'b0, irq)
         lm.send(9'h05A, 8, 1'b0, 1'b0, 1'b1);
         fork
            lm.send(9'h000, 8, 1'b0, 1'b0, 1'b1);
         join_none
         repeat (60) @(posedge i_clk);
         wr(URB_OFS_CTRL_B, 8'h00);
         repeat (3) @(posedge i_clk);
         `CHK("pin", 1'b0, ovr)
         repeat (150) @(posedge i_clk);
         wr(URB_OFS_CTRL_B, 8'h10);
         rd(URB_OFS_STAT_A);
         `CHK("flushed", 8'h00, rdat[7:0])
      end
   endtask : t_irq_flush

   initial
   begin
      repeat (6) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_clk);
      t_parity();
      t_frame();
      t_overrun();
      t_sizes();
      t_irq_flush();
      end_of_test();
   end
endmodule : urb_rx_bench
`default_nettype wire
